// File: inc/fps_pkg.sv
// constants, types and register map of the flash program/erase host controller
// Function
// (RULE1) device writes one byte and verifies it; host needs no verify pass
// (RULE2) host polls data-polling and toggle bits to detect programming end
// (RULE3) during program, data-polling bit reads inverted written bit, then true bit
// (RULE4) toggle status bit shows an automatic algorithm is still running
// (RULE5) chip erase clears whole array and verifies internally
// (RULE6) during erase data-polling bit reads 0, then 1 when finished
// (RULE7) host confirms erase end by data polling or toggle checking
// (RULE8) sector erase target chosen by address bits 13 to 18
// (RULE9) byte program takes about 9 us after final write pulse
// (RULE10) sector erase takes about 0.7 s after final write
// (RULE11) ready/busy goes busy 90 ns after program or erase becomes valid
// (RULE12) host holds write strobe at least 100 ns for sector protect
// (RULE13) host holds write strobe at least 100 ns for sector unprotect
// (RULE14) toggle bit inverts per read while running, stable once finished
package fps_pkg;

    // clock
    localparam int CLK_MHZ = 20;

    // flash pin timing, ns
    localparam int WRITE_PULSE_NS = 35;
    localparam int WRITE_HIGH_NS = 30;
    localparam int READ_ACCESS_NS = 90;
    localparam int BUSY_ASSERT_DELAY_NS = 90;
    localparam int PROTECT_PULSE_WIDTH_NS = 100;
    localparam int UNPROTECT_PULSE_WIDTH_NS = 100;
    // typical durations and limits
    localparam int PROGRAM_DURATION_NS = 9000;
    localparam int SECTOR_ERASE_DURATION_MS = 700;
    localparam int PROGRAM_LIMIT_US = 300;
    localparam int SECTOR_ERASE_LIMIT_S = 15;
    localparam int CHIP_ERASE_LIMIT_S = 120;

    // cycle counts, least times rounded up
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_ASSERT_CYC = (BUSY_ASSERT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int PROTECT_PULSE_CYC = (PROTECT_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int UNPROTECT_PULSE_CYC = (UNPROTECT_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_STAGES = 2;
    localparam longint PROGRAM_LIMIT_CYC = longint'(PROGRAM_LIMIT_US) * CLK_MHZ;
    localparam longint SECTOR_ERASE_LIMIT_CYC = longint'(SECTOR_ERASE_LIMIT_S) * CLK_MHZ * 1000000;
    localparam longint CHIP_ERASE_LIMIT_CYC = longint'(CHIP_ERASE_LIMIT_S) * CLK_MHZ * 1000000;

    // register byte offsets
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_ADDRESS = 8'h04;
    localparam logic [7:0] REG_WRITE_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_READ_DATA = 8'h10;
    localparam logic [7:0] REG_ELAPSED = 8'h14;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1c;

    // field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_GO_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PASS_BIT = 1;
    localparam int STAT_VERIFY_FAIL_BIT = 2;
    localparam int STAT_TIMEOUT_BIT = 3;
    localparam int STAT_READY_BIT = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERROR_BIT = 1;
    localparam int DATA_POLLING_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int SECTOR_SELECT_LOW_BIT = 13;
    localparam int SECTOR_SELECT_HIGH_BIT = 18;

    // reset values
    localparam logic [18:0] ADDRESS_RESET = 19'h00000;
    localparam logic [7:0] DATA_RESET = 8'hff;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // command cycle addresses and codes
    localparam logic [18:0] UNLOCK_ADDR_A = 19'h00555;
    localparam logic [18:0] UNLOCK_ADDR_B = 19'h002aa;
    localparam logic [7:0] UNLOCK_CODE_A = 8'haa;
    localparam logic [7:0] UNLOCK_CODE_B = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;

    typedef enum logic [2:0] {
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_READ,
        OP_PROTECT,
        OP_UNPROTECT
    } fps_op_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRITE_LOW,
        ST_WRITE_HIGH,
        ST_BUSY_WAIT,
        ST_READ,
        ST_READ_GAP,
        ST_DONE
    } fps_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fps_req_type;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fps_pins_type;

endpackage : fps_pkg

// File: src/fps_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fps_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : fps_sync

// File: src/fps_host.sv
// host controller driving flash program, erase, protect and status polling
`timescale 1ns/1ps
module fps_host #(
    parameter longint PROGRAM_LIMIT = fps_pkg::PROGRAM_LIMIT_CYC,
    parameter longint SECTOR_ERASE_LIMIT = fps_pkg::SECTOR_ERASE_LIMIT_CYC,
    parameter longint CHIP_ERASE_LIMIT = fps_pkg::CHIP_ERASE_LIMIT_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // register port
    input wire fps_pkg::fps_req_type sw_req_in,
    output logic [31:0] sw_rdata_out,
    output logic irq_out,
    // flash pins
    output fps_pkg::fps_pins_type flash_out,
    input wire logic [7:0] flash_dq_in,
    input wire logic ready_busy_output_in
);
    logic rst_sync1;
    logic rst_n;
    logic [7:0] dq_sync;
    logic ready_sync;
    fps_pkg::fps_state_type state;
    fps_pkg::fps_op_type op;
    logic [18:0] target_addr;
    logic [7:0] target_data;
    logic [2:0] step;
    logic [2:0] last_step;
    logic [3:0] cnt;
    logic [31:0] elapsed;
    logic [31:0] limit;
    logic [7:0] read_byte;
    logic [7:0] first_byte;
    logic have_first;
    logic pass;
    logic verify_fail;
    logic timeout;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] irq_set;
    logic [26:0] entry;
    logic expect_poll;
    logic [3:0] pulse_cyc;

    // reset release
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_sync1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_sync1 <= 1'b1;
            rst_n <= rst_sync1;
        end
    end

    fps_sync #(.WIDTH(9)) u_sync (
        .clock_in(clock_in),
        .rstn_in(rst_n),
        .async_in({ready_busy_output_in, flash_dq_in}),
        .sync_out({ready_sync, dq_sync})
    );

    // command cycle table
    always_comb
    begin
        entry = {fps_pkg::UNLOCK_ADDR_A, fps_pkg::UNLOCK_CODE_A};
        last_step = 3'd5;
        case (op)
            fps_pkg::OP_PROGRAM:
            begin
                last_step = 3'd3;
                case (step)
                    3'd1: entry = {fps_pkg::UNLOCK_ADDR_B, fps_pkg::UNLOCK_CODE_B};
                    3'd2: entry = {fps_pkg::UNLOCK_ADDR_A, fps_pkg::CMD_PROGRAM};
                    3'd3: entry = {target_addr, target_data}; // RULE1
                    default: entry = {fps_pkg::UNLOCK_ADDR_A, fps_pkg::UNLOCK_CODE_A};
                endcase
            end
            fps_pkg::OP_CHIP_ERASE, fps_pkg::OP_SECTOR_ERASE:
            begin
                case (step)
                    3'd1, 3'd4: entry = {fps_pkg::UNLOCK_ADDR_B, fps_pkg::UNLOCK_CODE_B};
                    3'd2: entry = {fps_pkg::UNLOCK_ADDR_A, fps_pkg::CMD_ERASE_SETUP};
                    3'd5:
                    begin
                        if (op == fps_pkg::OP_CHIP_ERASE)
                        begin
                            entry = {fps_pkg::UNLOCK_ADDR_A, fps_pkg::CMD_CHIP_ERASE}; // RULE5
                        end
                        else
                        begin
                            entry = {target_addr[fps_pkg::SECTOR_SELECT_HIGH_BIT:
                                                 fps_pkg::SECTOR_SELECT_LOW_BIT],
                                     13'h0000, fps_pkg::CMD_SECTOR_ERASE}; // RULE8
                        end
                    end
                    default: entry = {fps_pkg::UNLOCK_ADDR_A, fps_pkg::UNLOCK_CODE_A};
                endcase
            end
            default:
            begin
                last_step = 3'd0;
                entry = {target_addr, target_data};
            end
        endcase
    end

    // expected data-polling bit at completion
    always_comb
    begin
        expect_poll = 1'b1; // RULE6
        limit = 32'(CHIP_ERASE_LIMIT);
        pulse_cyc = 4'(fps_pkg::WRITE_PULSE_CYC);
        if (op == fps_pkg::OP_PROGRAM)
        begin
            expect_poll = target_data[fps_pkg::DATA_POLLING_BIT]; // RULE3
            limit = 32'(PROGRAM_LIMIT);
        end
        else if (op == fps_pkg::OP_SECTOR_ERASE)
        begin
            limit = 32'(SECTOR_ERASE_LIMIT);
        end
        if (op == fps_pkg::OP_PROTECT)
        begin
            pulse_cyc = 4'(fps_pkg::PROTECT_PULSE_CYC); // RULE12
        end
        else if (op == fps_pkg::OP_UNPROTECT)
        begin
            pulse_cyc = 4'(fps_pkg::UNPROTECT_PULSE_CYC); // RULE13
        end
    end

    wire logic go = sw_req_in.wr && sw_req_in.addr == fps_pkg::REG_CONTROL
        && sw_req_in.wdata[fps_pkg::CTRL_GO_BIT] && state == fps_pkg::ST_IDLE;
    wire logic polling = state == fps_pkg::ST_READ || state == fps_pkg::ST_READ_GAP;

    // software-written target registers
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            target_addr <= fps_pkg::ADDRESS_RESET;
            target_data <= fps_pkg::DATA_RESET;
            op <= fps_pkg::OP_READ;
            irq_mask <= fps_pkg::IRQ_MASK_RESET;
        end
        else if (sw_req_in.wr)
        begin
            if (sw_req_in.addr == fps_pkg::REG_ADDRESS && state == fps_pkg::ST_IDLE)
            begin
                target_addr <= sw_req_in.wdata[18:0];
            end
            else if (sw_req_in.addr == fps_pkg::REG_WRITE_DATA && state == fps_pkg::ST_IDLE)
            begin
                target_data <= sw_req_in.wdata[7:0];
            end
            else if (sw_req_in.addr == fps_pkg::REG_IRQ_MASK)
            begin
                irq_mask <= sw_req_in.wdata[1:0];
            end
            else if (go)
            begin
                op <= fps_pkg::fps_op_type'(sw_req_in.wdata[fps_pkg::CTRL_OP_LSB +: 3]);
            end
        end
    end

    // sequencer
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= fps_pkg::ST_IDLE;
            step <= 3'd0;
            cnt <= 4'h0;
            flash_out <= {19'h00000, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};
            read_byte <= 8'h00;
            first_byte <= 8'h00;
            have_first <= 1'b0;
            pass <= 1'b0;
            verify_fail <= 1'b0;
            timeout <= 1'b0;
        end
        else
        begin
            case (state)
                fps_pkg::ST_IDLE:
                begin
                    step <= 3'd0;
                    have_first <= 1'b0;
                    if (go)
                    begin
                        pass <= 1'b0;
                        verify_fail <= 1'b0;
                        timeout <= 1'b0;
                        if (sw_req_in.wdata[fps_pkg::CTRL_OP_LSB +: 3] == 3'(fps_pkg::OP_READ))
                        begin
                            flash_out.addr <= target_addr;
                            flash_out.ce_n <= 1'b0;
                            flash_out.oe_n <= 1'b0;
                            cnt <= 4'(fps_pkg::READ_ACCESS_CYC + fps_pkg::SYNC_STAGES);
                            state <= fps_pkg::ST_READ;
                        end
                        else
                        begin
                            state <= fps_pkg::ST_WRITE_HIGH;
                            cnt <= 4'h0;
                        end
                    end
                end
                fps_pkg::ST_WRITE_LOW:
                begin
                    if (cnt <= 4'h1)
                    begin
                        flash_out.we_n <= 1'b1;
                        cnt <= 4'(fps_pkg::WRITE_HIGH_CYC);
                        state <= fps_pkg::ST_WRITE_HIGH;
                    end
                    else
                    begin
                        cnt <= cnt - 4'h1;
                    end
                end
                fps_pkg::ST_WRITE_HIGH:
                begin
                    if (cnt > 4'h1)
                    begin
                        cnt <= cnt - 4'h1;
                    end
                    else if (flash_out.dq_oe && step == last_step)
                    begin
                        flash_out.dq_oe <= 1'b0;
                        flash_out.ce_n <= 1'b1;
                        if (op == fps_pkg::OP_PROTECT || op == fps_pkg::OP_UNPROTECT)
                        begin
                            pass <= 1'b1;
                            state <= fps_pkg::ST_DONE;
                        end
                        else
                        begin
                            cnt <= 4'(fps_pkg::BUSY_ASSERT_CYC); // RULE11
                            state <= fps_pkg::ST_BUSY_WAIT;
                        end
                    end
                    else
                    begin
                        if (flash_out.dq_oe)
                        begin
                            step <= step + 3'd1;
                        end
                        flash_out.addr <= flash_out.dq_oe ? flash_out.addr : entry[26:8];
                        flash_out.dq <= flash_out.dq_oe ? flash_out.dq : entry[7:0];
                        flash_out.dq_oe <= 1'b0;
                        state <= fps_pkg::ST_WRITE_HIGH;
                        if (!flash_out.dq_oe)
                        begin
                            flash_out.dq_oe <= 1'b1;
                            flash_out.ce_n <= 1'b0;
                            flash_out.we_n <= 1'b0;
                            cnt <= pulse_cyc;
                            state <= fps_pkg::ST_WRITE_LOW;
                        end
                    end
                end
                fps_pkg::ST_BUSY_WAIT:
                begin
                    if (cnt <= 4'h1)
                    begin
                        flash_out.addr <= target_addr;
                        flash_out.ce_n <= 1'b0;
                        flash_out.oe_n <= 1'b0;
                        cnt <= 4'(fps_pkg::READ_ACCESS_CYC + fps_pkg::SYNC_STAGES);
                        state <= fps_pkg::ST_READ;
                    end
                    else
                    begin
                        cnt <= cnt - 4'h1;
                    end
                end
                fps_pkg::ST_READ:
                begin
                    if (cnt <= 4'h1)
                    begin
                        read_byte <= dq_sync;
                        flash_out.oe_n <= 1'b1;
                        flash_out.ce_n <= 1'b1;
                        state <= fps_pkg::ST_READ_GAP;
                    end
                    else
                    begin
                        cnt <= cnt - 4'h1;
                    end
                end
                fps_pkg::ST_READ_GAP:
                begin
                    if (op == fps_pkg::OP_READ)
                    begin
                        pass <= 1'b1;
                        state <= fps_pkg::ST_DONE;
                    end
                    else if (have_first && read_byte[fps_pkg::TOGGLE_STATUS_BIT]
                             == first_byte[fps_pkg::TOGGLE_STATUS_BIT]) // RULE14
                    begin
                        if (read_byte[fps_pkg::DATA_POLLING_BIT] == expect_poll) // RULE2 RULE7
                        begin
                            pass <= 1'b1;
                        end
                        else
                        begin
                            verify_fail <= 1'b1;
                        end
                        state <= fps_pkg::ST_DONE;
                    end
                    else if (elapsed >= limit)
                    begin
                        timeout <= 1'b1;
                        state <= fps_pkg::ST_DONE;
                    end
                    else
                    begin
                        first_byte <= read_byte; // RULE4
                        have_first <= 1'b1;
                        flash_out.ce_n <= 1'b0;
                        flash_out.oe_n <= 1'b0;
                        cnt <= 4'(fps_pkg::READ_ACCESS_CYC + fps_pkg::SYNC_STAGES);
                        state <= fps_pkg::ST_READ;
                    end
                end
                default:
                begin
                    state <= fps_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // duration since final write, typically 9 us program, 0.7 s sector erase
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            elapsed <= 32'h00000000;
        end
        else if (go)
        begin
            elapsed <= 32'h00000000;
        end
        else if ((state == fps_pkg::ST_BUSY_WAIT || polling) && op != fps_pkg::OP_READ)
        begin
            elapsed <= elapsed + 32'h00000001; // RULE9 RULE10
        end
    end

    // sticky interrupt status, set wins over clear
    assign irq_set = {state == fps_pkg::ST_DONE && (verify_fail || timeout),
                      state == fps_pkg::ST_DONE};
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= 2'h0;
        end
        else if (sw_req_in.wr && sw_req_in.addr == fps_pkg::REG_IRQ_STATUS)
        begin
            irq_status <= (irq_status & ~sw_req_in.wdata[1:0]) | irq_set;
        end
        else
        begin
            irq_status <= irq_status | irq_set;
        end
    end
    assign irq_out = |(irq_status & irq_mask);

    // read data, one cycle after strobe
    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_rdata_out <= 32'h00000000;
        end
        else if (!sw_req_in.rd)
        begin
            sw_rdata_out <= 32'h00000000;
        end
        else if (sw_req_in.addr == fps_pkg::REG_CONTROL)
        begin
            sw_rdata_out <= {29'h00000000, 3'(op)};
        end
        else if (sw_req_in.addr == fps_pkg::REG_ADDRESS)
        begin
            sw_rdata_out <= {13'h0000, target_addr};
        end
        else if (sw_req_in.addr == fps_pkg::REG_WRITE_DATA)
        begin
            sw_rdata_out <= {24'h000000, target_data};
        end
        else if (sw_req_in.addr == fps_pkg::REG_STATUS)
        begin
            sw_rdata_out <= {27'h0000000, ready_sync, timeout, verify_fail, pass,
                             state != fps_pkg::ST_IDLE};
        end
        else if (sw_req_in.addr == fps_pkg::REG_READ_DATA)
        begin
            sw_rdata_out <= {24'h000000, read_byte};
        end
        else if (sw_req_in.addr == fps_pkg::REG_ELAPSED)
        begin
            sw_rdata_out <= elapsed;
        end
        else if (sw_req_in.addr == fps_pkg::REG_IRQ_STATUS)
        begin
            sw_rdata_out <= {30'h00000000, irq_status};
        end
        else if (sw_req_in.addr == fps_pkg::REG_IRQ_MASK)
        begin
            sw_rdata_out <= {30'h00000000, irq_mask};
        end
        else
        begin
            sw_rdata_out <= 32'h00000000;
        end
    end
endmodule : fps_host

// File: verification/fps_host_props.sv
// assertions on the flash host controller pins
`timescale 1ns/1ps
module fps_host_props #(
    parameter longint PROGRAM_LIMIT = 1,
    parameter longint SECTOR_ERASE_LIMIT = 1,
    parameter longint CHIP_ERASE_LIMIT = 1
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // register port
    input wire fps_pkg::fps_req_type sw_req_in,
    input wire logic [31:0] sw_rdata_out,
    input wire logic irq_out,
    // flash pins
    input wire fps_pkg::fps_pins_type flash_out,
    input wire logic [7:0] flash_dq_in,
    input wire logic ready_busy_output_in
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);
    sequence poll_read;
        !flash_out.oe_n [*4] ##1 flash_out.oe_n;
    endsequence
    property sector_write;
        !flash_out.we_n && flash_out.dq == fps_pkg::CMD_SECTOR_ERASE |-> flash_out.addr[12:0] == 13'h0;
    endproperty
    poll_length_a: assert property ($fell(flash_out.oe_n) |-> poll_read)
        else $error("status read strobe not four cycles");
    bus_turn_a: assert property (!flash_out.oe_n |-> !flash_out.dq_oe && flash_out.we_n)
        else $error("host drives data during a read");
    sector_addr_a: assert property (sector_write)
        else $error("sector erase address has low bits set");
    write_drive_a: assert property ($fell(flash_out.we_n) |-> flash_out.dq_oe && !flash_out.ce_n)
        else $error("write strobe without data or chip enable");
    busy_wait_a: assert property ($rose(flash_out.ce_n) && $fell(flash_out.dq_oe)
        |-> flash_out.oe_n [*2])
        else $error("status read too soon after final write");
endmodule : fps_host_props
bind fps_host fps_host_props #(.PROGRAM_LIMIT(PROGRAM_LIMIT),
    .SECTOR_ERASE_LIMIT(SECTOR_ERASE_LIMIT), .CHIP_ERASE_LIMIT(CHIP_ERASE_LIMIT)) i_props (
    .clock_in(clock_in), .rstn_in(rstn_in), .sw_req_in(sw_req_in), .sw_rdata_out(sw_rdata_out),
    .irq_out(irq_out), .flash_out(flash_out), .flash_dq_in(flash_dq_in),
    .ready_busy_output_in(ready_busy_output_in));

// File: verification/fps_flash_model.sv
// behavioural flash device answering the host pins
`timescale 1ns/1ps
module fps_flash_model #(
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 60
) (
    // clock and pins
    input wire logic clock_in,
    input wire fps_pkg::fps_pins_type pins_in,
    // answers
    output logic [7:0] dq_out,
    output logic ready_busy_out
);
    logic [7:0] mem [int];
    logic [7:0] last = 8'h00;
    logic [7:0] want = 8'h00;
    logic prog = 1'b0;
    logic esetup = 1'b0;
    logic erasing = 1'b0;
    logic tgl = 1'b0;
    int busy = 0;
    function automatic logic [7:0] peek(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : peek
    always @(posedge pins_in.we_n)
    begin
        if (prog)
        begin
            want = pins_in.dq;
            mem[int'(pins_in.addr)] = peek(int'(pins_in.addr)) & want;
            prog = 1'b0;
            erasing = 1'b0;
            busy = PROG_CYC;
        end
        else if (esetup && pins_in.dq inside {fps_pkg::CMD_CHIP_ERASE, fps_pkg::CMD_SECTOR_ERASE})
        begin
            foreach (mem[a])
                if (pins_in.dq == fps_pkg::CMD_CHIP_ERASE || a[18:13] == pins_in.addr[18:13])
                    mem[a] = 8'hff;
            esetup = 1'b0;
            erasing = 1'b1;
            busy = ERASE_CYC;
        end
        else if (pins_in.dq == fps_pkg::CMD_PROGRAM)
            prog = 1'b1;
        else if (pins_in.dq == fps_pkg::CMD_ERASE_SETUP)
            esetup = 1'b1;
    end
    always @(posedge clock_in)
        if (busy > 0)
            busy = busy - 1;
    // status or array byte per read, both polling bits valid
    always @(negedge pins_in.oe_n)
    begin
        if (busy > 0)
        begin
            tgl = ~tgl;
            last = {erasing ? 1'b0 : ~want[7], tgl, 6'h00};
        end
        else
            last = peek(int'(pins_in.addr));
    end
    assign dq_out = (pins_in.oe_n || pins_in.ce_n) ? ~last : last;
    assign ready_busy_out = (busy == 0);
endmodule : fps_flash_model

// File: verification/tb_top.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_top;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    fps_pkg::fps_req_type req = '0;
    logic [31:0] rdata;
    logic irq;
    fps_pkg::fps_pins_type pins;
    logic [7:0] dq;
    logic rb;
    logic [31:0] v;
    int failures = 0;
    int n_checks = 0;
    int wlow = 0;
    int wmax = 0;
    fps_host #(.PROGRAM_LIMIT(200), .SECTOR_ERASE_LIMIT(400), .CHIP_ERASE_LIMIT(58)) i_dut (
        .clock_in(clock_in), .rstn_in(rstn_in), .sw_req_in(req), .sw_rdata_out(rdata),
        .irq_out(irq), .flash_out(pins), .flash_dq_in(dq), .ready_busy_output_in(rb));
    fps_flash_model i_flash (.clock_in(clock_in), .pins_in(pins), .dq_out(dq),
        .ready_busy_out(rb));
    initial
        forever #25 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        wlow <= pins.we_n ? 0 : wlow + 1;
        wmax <= pins.we_n ? wmax : wlow + 1;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_in);
        req <= '0;
        @(posedge clock_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock_in);
        req <= '0;
        #1 d = rdata;
        @(posedge clock_in);
    endtask : rd
    // one operation to completion, then its result bits
    task automatic run(input logic [18:0] a, input logic [7:0] d, input logic [2:0] op,
        input logic [2:0] exp);
        logic [31:0] s;
        int n;
        wr(fps_pkg::REG_ADDRESS, {13'h0, a});
        wr(fps_pkg::REG_WRITE_DATA, {24'h0, d});
        wr(fps_pkg::REG_CONTROL, {29'h1, op});
        s = 32'h1;
        n = 0;
        while (s[0] !== 1'b0 && n < 3000)
        begin
            rd(fps_pkg::REG_STATUS, s);
            n++;
        end
        if (n == 3000)
            failures++;
        check("status", {28'h0, s[4:1]}, {28'h0, 1'b1, exp});
    endtask : run
    initial
    begin
        repeat (16) @(posedge clock_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rd(8'h20, v);
        check("unmapped", v, 32'h0);
        wr(fps_pkg::REG_IRQ_MASK, 32'h3);
        run(19'h00123, 8'h5a, fps_pkg::OP_PROGRAM, 3'h1);
        check("irq", {31'h0, irq}, 32'h1);
        rd(fps_pkg::REG_ELAPSED, v);
        check("elapsed", {31'h0, v >= 32'h14}, 32'h1);
        wr(fps_pkg::REG_IRQ_STATUS, 32'h3);
        check("irq", {31'h0, irq}, 32'h0);
        run(19'h00123, 8'h00, fps_pkg::OP_PROGRAM, 3'h1);
        run(19'h00123, 8'h80, fps_pkg::OP_PROGRAM, 3'h2);
        run(19'h40010, 8'h3c, fps_pkg::OP_PROGRAM, 3'h1);
        run(19'h00005, 8'h00, fps_pkg::OP_SECTOR_ERASE, 3'h1);
        run(19'h00123, 8'h00, fps_pkg::OP_READ, 3'h1);
        rd(fps_pkg::REG_READ_DATA, v);
        check("erased", v, 32'hff);
        run(19'h40010, 8'h00, fps_pkg::OP_READ, 3'h1);
        rd(fps_pkg::REG_READ_DATA, v);
        check("kept", v, 32'h3c);
        wr(fps_pkg::REG_IRQ_STATUS, 32'h3);
        wr(fps_pkg::REG_IRQ_MASK, 32'h0);
        run(19'h00000, 8'h00, fps_pkg::OP_CHIP_ERASE, 3'h4);
        check("masked", {31'h0, irq}, 32'h0);
        wr(fps_pkg::REG_IRQ_MASK, 32'h3);
        check("unmasked", {31'h0, irq}, 32'h1);
        run(19'h40010, 8'h00, fps_pkg::OP_READ, 3'h1);
        rd(fps_pkg::REG_READ_DATA, v);
        check("chip", v, 32'hff);
        run(19'h00000, 8'h00, fps_pkg::OP_PROTECT, 3'h1);
        check("protect", wmax, fps_pkg::PROTECT_PULSE_CYC);
        run(19'h00000, 8'h00, fps_pkg::OP_UNPROTECT, 3'h1);
        check("unprotect", wmax, fps_pkg::UNPROTECT_PULSE_CYC);
        print_verdict;
    end
endmodule : tb_top
